// ---- core/mcu_incdec_halt_exec.sv ----
// Execution core for increment, decrement and power-down, APB register slave
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "incdec_params.svh"

module mcu_incdec_halt_exec (
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic                  wake,
    input  wire logic                  wdt_expire,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       clk_run,
    output logic                       wdt_clear,
    output logic      [7:0]            acc,
    output var incdec_pkg::status_t    status
);

    logic [7:0]           mem      [`MEM_DEPTH];
    logic [7:0]           next_mem [`MEM_DEPTH];
    logic [`MEM_AW-1:0]   mem_ptr;
    logic [`MEM_AW-1:0]   next_mem_ptr;
    logic [7:0]           next_acc;
    incdec_pkg::status_t  next_status;
    incdec_pkg::state_t   state;
    incdec_pkg::state_t   next_state;
    logic [31:0]          next_prdata;
    logic                 next_pready;
    logic                 next_pslverr;
    logic                 next_clk_run;
    logic                 next_wdt_clear;

    logic                 setup_done;
    logic                 commit;
    logic                 wr_ok;
    logic                 exec_go;
    incdec_pkg::op_t      op;
    logic [`MEM_AW-1:0]   op_adr;
    logic [7:0]           operand;
    logic [7:0]           result;

    // Wrapping 8-bit step up or down
    function automatic logic [7:0] step8(input logic [7:0] v,
                                         input logic       up);
        logic [8:0] s;
        s = up ? ({1'b0, v} + {1'b0, `BYTE_ONE})
               : ({1'b0, v} - {1'b0, `BYTE_ONE});
        return s[7:0];
    endfunction

    function automatic logic reg_hit(input logic [31:0] a);
        return (a == `OFS_INSTR) || (a == `OFS_ACC) ||
               (a == `OFS_STATUS) || (a == `OFS_MEM_PTR) ||
               (a == `OFS_MEM_DATA);
    endfunction

    always_comb begin
        setup_done = psel && penable && !pready;
        commit     = psel && penable && pready;
        // Follow the refusal already on pslverr, so a wake that lands
        // mid-transfer cannot let a refused write slip through
        wr_ok      = commit && pwrite && !pslverr;
        exec_go    = wr_ok && (paddr == `OFS_INSTR);
        op         = incdec_pkg::op_t'(pwdata[`INSTR_OP_MSB:`INSTR_OP_LSB]);
        op_adr     = pwdata[`INSTR_ADR_MSB:`INSTR_ADR_LSB];
        operand    = mem[op_adr];
        result     = step8(operand, op != incdec_pkg::OP_DEC_ACC);
    end

    // Bus answer: ready one cycle into the access phase
    always_comb begin
        next_pready  = setup_done;
        next_pslverr = 1'b0;
        next_prdata  = `WORD_ZERO;
        if (setup_done) begin
            // Writes while powered down are refused so state stays frozen
            next_pslverr = !reg_hit(paddr) ||
                           (pwrite && state == incdec_pkg::ST_HALTED);
            if (!pwrite) begin
                case (paddr)
                    `OFS_ACC:      next_prdata = {24'h00_0000, acc};
                    `OFS_STATUS:   next_prdata = {28'h000_0000, status};
                    `OFS_MEM_PTR:  next_prdata = {27'h000_0000, mem_ptr};
                    `OFS_MEM_DATA: next_prdata = {24'h00_0000, mem[mem_ptr]};
                    default:       next_prdata = `WORD_ZERO;
                endcase
            end
        end
    end

    always_comb begin
        next_acc     = acc;
        next_mem_ptr = mem_ptr;
        next_mem     = mem;
        if (wr_ok && paddr == `OFS_ACC) begin
            next_acc = pwdata[7:0];
        end
        if (wr_ok && paddr == `OFS_MEM_PTR) begin
            next_mem_ptr = pwdata[`MEM_AW-1:0];
        end
        if (wr_ok && paddr == `OFS_MEM_DATA) begin
            next_mem[mem_ptr] = pwdata[7:0];
        end
        if (exec_go) begin
            case (op)
                incdec_pkg::OP_DEC_ACC: begin
                    next_acc = result;
                end
                incdec_pkg::OP_INC_MEM: begin
                    next_mem[op_adr] = result;
                end
                incdec_pkg::OP_INC_ACC: begin
                    next_acc = result;
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        next_status        = status;
        next_state         = state;
        next_wdt_clear     = 1'b0;
        if (wr_ok && paddr == `OFS_STATUS) begin
            next_status.zero = pwdata[`ST_ZERO_BIT];
            if (pwdata[`ST_PDF_BIT]) begin
                next_status.power_down_flag = 1'b0;
            end
            if (pwdata[`ST_TO_BIT]) begin
                next_status.watchdog_expiry_flag = 1'b0;
            end
        end
        if (exec_go) begin
            case (op)
                incdec_pkg::OP_DEC_ACC,
                incdec_pkg::OP_INC_MEM,
                incdec_pkg::OP_INC_ACC: begin
                    next_status.zero = (result == `BYTE_ZERO);
                end
                incdec_pkg::OP_HALT: begin
                    next_status.power_down_flag      = 1'b1;
                    next_status.watchdog_expiry_flag = 1'b0;
                    next_wdt_clear = 1'b1;
                    next_state     = incdec_pkg::ST_HALTED;
                end
                default: begin
                end
            endcase
        end
        if (state == incdec_pkg::ST_HALTED && wake) begin
            next_state = incdec_pkg::ST_RUN;
        end
        // An expiry in the same cycle as a clear still lands
        if (wdt_expire) begin
            next_status.watchdog_expiry_flag = 1'b1;
        end
        next_status.halted = (next_state == incdec_pkg::ST_HALTED);
        next_clk_run       = (next_state == incdec_pkg::ST_RUN);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `MEM_DEPTH; i++) begin
                mem[i] <= `BYTE_ZERO;
            end
            mem_ptr   <= `RST_PTR;
            acc       <= `RST_ACC;
            status    <= '0;
            state     <= incdec_pkg::ST_RUN;
            prdata    <= `WORD_ZERO;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            clk_run   <= 1'b1;
            wdt_clear <= 1'b0;
        end else begin
            mem       <= next_mem;
            mem_ptr   <= next_mem_ptr;
            acc       <= next_acc;
            status    <= next_status;
            state     <= next_state;
            prdata    <= next_prdata;
            pready    <= next_pready;
            pslverr   <= next_pslverr;
            clk_run   <= next_clk_run;
            wdt_clear <= next_wdt_clear;
        end
    end

    // Checking helpers: what the last executed instruction saw
    incdec_pkg::op_t      chk_op;
    logic [`MEM_AW-1:0]   chk_adr;
    logic [7:0]           chk_val;
    logic                 chk_exp;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            chk_op  <= incdec_pkg::OP_NONE;
            chk_adr <= `RST_PTR;
            chk_val <= `BYTE_ZERO;
            chk_exp <= 1'b0;
        end else begin
            chk_op  <= exec_go ? op : incdec_pkg::OP_NONE;
            chk_adr <= op_adr;
            chk_val <= operand;
            chk_exp <= wdt_expire;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    dec_to_acc_a: assert property (
        chk_op == incdec_pkg::OP_DEC_ACC |->
            acc == chk_val - `BYTE_ONE && status.zero == (acc == `BYTE_ZERO))
        else $error("decrement result or zero flag wrong");

    dec_keeps_mem_a: assert property (
        chk_op == incdec_pkg::OP_DEC_ACC |-> mem[chk_adr] == chk_val)
        else $error("decrement altered memory");

    halt_stops_a: assert property (
        state == incdec_pkg::ST_HALTED && !wake |=>
            state == incdec_pkg::ST_HALTED && !clk_run && !wdt_clear)
        else $error("halted core left power down without wake");

    halt_retains_a: assert property (
        state == incdec_pkg::ST_HALTED && !wake |=>
            $stable(acc) && $stable(mem_ptr) && $stable(mem[mem_ptr])
            && $stable(status.zero))
        else $error("state changed during power down");

    halt_wdt_clear_a: assert property (
        chk_op == incdec_pkg::OP_HALT |-> wdt_clear ##1 !wdt_clear)
        else $error("watchdog clear pulse missing");

    halt_flags_a: assert property (
        chk_op == incdec_pkg::OP_HALT |->
            status.power_down_flag && (chk_exp || !status.watchdog_expiry_flag)
            && status.zero == $past(status.zero) && !clk_run)
        else $error("power down flags wrong");

    inc_in_place_a: assert property (
        chk_op == incdec_pkg::OP_INC_MEM |->
            mem[chk_adr] == chk_val + `BYTE_ONE && $stable(acc)
            && status.zero == (mem[chk_adr] == `BYTE_ZERO))
        else $error("in-place increment wrong");

    inc_to_acc_a: assert property (
        chk_op == incdec_pkg::OP_INC_ACC |->
            acc == chk_val + `BYTE_ONE && mem[chk_adr] == chk_val)
        else $error("increment to accumulator wrong");

    wrap_around_a: assert property (
        chk_op == incdec_pkg::OP_INC_ACC && chk_val == 8'hff |->
            acc == `BYTE_ZERO && status.zero)
        else $error("increment did not wrap");

    apb_answer_a: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("bus answer not one cycle");

    // Power-down entry, exit and refusal of writes while halted
    halt_enter_a: assert property (
        exec_go && op == incdec_pkg::OP_HALT |=>
            status.halted && !clk_run && status.power_down_flag)
        else $error("power down not entered");

    halted_err_a: assert property (
        status.halted && pready && pwrite |-> pslverr)
        else $error("write accepted while powered down");

    refused_write_a: assert property (
        pready && pslverr && pwrite |=>
            $stable(acc) && $stable(mem_ptr) && $stable(status.zero))
        else $error("refused write changed state");

    wdt_clear_only_a: assert property (
        wdt_clear |-> chk_op == incdec_pkg::OP_HALT)
        else $error("watchdog clear without power down");

    wake_resume_a: assert property (
        state == incdec_pkg::ST_HALTED && wake |=> clk_run && !status.halted)
        else $error("wake did not resume the core");

    expiry_wins_a: assert property (
        wdt_expire |=> status.watchdog_expiry_flag)
        else $error("watchdog expiry lost");

    read_upper_a: assert property (
        pready |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");

    // Scenarios worth seeing at least once
    halt_seen_c: cover property (
        exec_go && op == incdec_pkg::OP_HALT ##[1:20] wake);
    dec_zero_c: cover property (
        chk_op == incdec_pkg::OP_DEC_ACC && status.zero);
    inc_wrap_c: cover property (
        chk_op == incdec_pkg::OP_INC_MEM && chk_val == 8'hff);
    refused_write_c: cover property (pready && pslverr && pwrite);
    dec_wrap_c: cover property (
        chk_op == incdec_pkg::OP_DEC_ACC && chk_val == `BYTE_ZERO);

endmodule
`default_nettype wire

// ---- include/incdec_params.svh ----
// Constants for the increment, decrement and power-down execution block
// Function
// - Decrement-to-accumulator loads memory byte minus one, updates zero flag.
// - Decrement-to-accumulator leaves the memory byte untouched.
// - Power-down stops execution and gates the system clock off.
// - While powered down, memory and registers keep their contents.
// - Power-down clears the watchdog timer and its prescaler.
// - Power-down sets power-down flag, clears watchdog expiry flag, nothing else. The code also sets the halted status bit.
// - Increment-in-place writes memory byte plus one back, updates zero flag.
// - Add-one-to-accumulator loads byte plus one, memory unchanged.
`ifndef INCDEC_PARAMS_SVH
`define INCDEC_PARAMS_SVH

`define MEM_DEPTH       32
`define MEM_AW          5
`define DATA_W          8
`define BYTE_ONE        8'h01
`define BYTE_ZERO       8'h00
`define WORD_ZERO       32'h0000_0000

`define OFS_INSTR       32'h0000_0000
`define OFS_ACC         32'h0000_0004
`define OFS_STATUS      32'h0000_0008
`define OFS_MEM_PTR     32'h0000_000c
`define OFS_MEM_DATA    32'h0000_0010

`define INSTR_OP_LSB    0
`define INSTR_OP_MSB    2
`define INSTR_ADR_LSB   8
`define INSTR_ADR_MSB   12

`define ST_ZERO_BIT     0
`define ST_PDF_BIT      1
`define ST_TO_BIT       2
`define ST_HALT_BIT     3

`define RST_ACC         8'h00
`define RST_PTR         5'h00

`endif

// ---- include/incdec_pkg.sv ----
// Types for the increment, decrement and power-down execution block
package incdec_pkg;

    typedef enum logic [2:0] {
        OP_NONE     = 3'b000,
        OP_DEC_ACC  = 3'b001,
        OP_INC_MEM  = 3'b010,
        OP_INC_ACC  = 3'b011,
        OP_HALT     = 3'b100
    } op_t;

    typedef enum logic [0:0] {
        ST_RUN    = 1'b0,
        ST_HALTED = 1'b1
    } state_t;

    typedef struct packed {
        logic halted;
        logic watchdog_expiry_flag;
        logic power_down_flag;
        logic zero;
    } status_t;

endpackage

// ---- sim/tb_top.sv ----
// Self-checking bench for the increment, decrement and power-down block
`timescale 1ns/1ps
`default_nettype none
`include "incdec_params.svh"

module tb_top;
    logic                   mclk = 1'b0;
    logic                   arst_n = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [31:0]            paddr = 32'h0;
    logic [31:0]            pwdata = 32'h0;
    logic                   wake = 1'b0;
    logic                   wdt_expire = 1'b0;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   clk_run;
    logic                   wdt_clear;
    logic [7:0]             acc;
    incdec_pkg::status_t    status;
    logic [31:0]            rdat;
    logic                   rerr;
    int                     fail_count = 0;
    int                     samples_checked = 0;
    int                     cycles = 0;

    mcu_incdec_halt_exec mcu_incdec_halt_exec_inst (
        .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .wake(wake),
        .wdt_expire(wdt_expire), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_run(clk_run), .wdt_clear(wdt_clear),
        .acc(acc), .status(status)
    );

    always #2.5 mclk = ~mclk;

    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cuts a hung handshake short
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 5000) begin
            fail_count++;
            close_out;
        end
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the committed result reach the outputs before callers look
        @(posedge mclk);
    endtask

    task automatic exec(input logic [2:0] op, input logic [4:0] adr);
        apb(1'b1, `OFS_INSTR, {19'h0, adr, 5'h0, op});
    endtask

    task automatic setmem(input logic [4:0] adr, input logic [7:0] v);
        apb(1'b1, `OFS_MEM_PTR, {27'h0, adr});
        apb(1'b1, `OFS_MEM_DATA, {24'h0, v});
    endtask

    task automatic getmem(input logic [4:0] adr);
        apb(1'b1, `OFS_MEM_PTR, {27'h0, adr});
        apb(1'b0, `OFS_MEM_DATA, 32'h0);
    endtask

    task automatic t_dec;
        setmem(5'h03, 8'h00);
        exec(3'h1, 5'h03);
        chk("dec acc", 32'hff, {24'h0, acc});
        chk("dec zero", 32'h0, {31'h0, status.zero});
        getmem(5'h03);
        chk("dec mem", 32'h0, rdat);
        setmem(5'h03, 8'h01);
        exec(3'h1, 5'h03);
        chk("dec acc", 32'h0, {24'h0, acc});
        chk("dec zero", 32'h1, {31'h0, status.zero});
        $display("test dec done");
    endtask

    task automatic t_inc_mem;
        setmem(5'h1f, 8'hff);
        exec(3'h2, 5'h1f);
        chk("inc zero", 32'h1, {31'h0, status.zero});
        getmem(5'h1f);
        chk("inc mem", 32'h0, rdat);
        setmem(5'h02, 8'h7f);
        exec(3'h2, 5'h02);
        chk("inc zero", 32'h0, {31'h0, status.zero});
        getmem(5'h02);
        chk("inc mem", 32'h80, rdat);
        $display("test inc_mem done");
    endtask

    task automatic t_inc_acc;
        setmem(5'h07, 8'h41);
        apb(1'b1, `OFS_ACC, 32'h0);
        exec(3'h3, 5'h07);
        chk("add_one_to_accumulator acc", 32'h42, {24'h0, acc});
        getmem(5'h07);
        chk("add_one_to_accumulator mem", 32'h41, rdat);
        exec(3'h0, 5'h07);
        chk("nop acc", 32'h42, {24'h0, acc});
        setmem(5'h07, 8'hff);
        exec(3'h3, 5'h07);
        chk("add_one_to_accumulator wrap", 32'h0, {24'h0, acc});
        chk("add_one_to_accumulator zero", 32'h1, {31'h0, status.zero});
        apb(1'b0, `OFS_ACC, 32'h0);
        chk("acc read", 32'h0, rdat);
        $display("test inc_acc done");
    endtask

    task automatic t_halt;
        setmem(5'h09, 8'h5a);
        apb(1'b1, `OFS_ACC, 32'h33);
        @(posedge mclk);
        wdt_expire <= 1'b1;
        @(posedge mclk);
        wdt_expire <= 1'b0;
        @(posedge mclk);
        chk("expiry set", 32'h1, {31'h0, status[2]});
        exec(3'h4, 5'h00);
        chk("clk_run", 32'h0, {31'h0, clk_run});
        chk("wdt_clear", 32'h1, {31'h0, wdt_clear});
        chk("halt flags", 32'h5, {29'h0, status[3:1]});
        @(posedge mclk);
        chk("wdt_clear", 32'h0, {31'h0, wdt_clear});
        apb(1'b1, `OFS_ACC, 32'h55);
        chk("halted write", 32'h1, {31'h0, rerr});
        exec(3'h3, 5'h09);
        chk("halted acc", 32'h33, {24'h0, acc});
        apb(1'b0, `OFS_MEM_DATA, 32'h0);
        chk("halted mem", 32'h5a, rdat);
        @(posedge mclk);
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        @(posedge mclk);
        chk("woken", 32'h1, {31'h0, clk_run});
        chk("pdf kept", 32'h1, {31'h0, status[1]});
        chk("resumed", 32'h0, {31'h0, status.halted});
        apb(1'b1, `OFS_STATUS, 32'h2);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("status clear", 32'h0, rdat);
        $display("test halt done");
    endtask

    task automatic t_unmapped;
        apb(1'b0, 32'h0000_0020, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdat);
        $display("test unmapped done");
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        t_dec;
        t_inc_mem;
        t_inc_acc;
        t_halt;
        t_unmapped;
        close_out;
    end
endmodule
`default_nettype wire
